// file: verilog/circ_addr_gen.sv
// circular buffer address correction for three generators: x read, x write
// and y, bit-reversed correction for x write only; registers reached over AHB-Lite
// assumes requests come from core logic on mclk, no synchronisers needed
//
// Design decisions made here: the AHB-Lite slave port and the register addresses.

module circ_addr_gen
   import circ_addr_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire agen_req_t xrReq,
   input wire agen_req_t xwReq,
   input wire agen_req_t yReq,
   output agen_rsp_t xrRsp,
   output agen_rsp_t xwRsp,
   output agen_rsp_t yRsp
);

   localparam int unsigned NGEN = 3;
   localparam int unsigned GEN_XR = 0;
   localparam int unsigned GEN_XW = 1;
   localparam int unsigned GEN_Y = 2;

   // registers
   logic [15:0] xStart_r, xEnd_r, yStart_r, yEnd_r, control_r, bitrev_r;
   logic [15:0] xStart_nxt, xEnd_nxt, yStart_nxt, yEnd_nxt, control_nxt, bitrev_nxt;
   logic wrPend_r;
   logic [DEC_W-1:0] wrAddr_r;
   logic [31:0] hrdata_r;
   logic [31:0] rdData;

   // true when a decoded byte address matches a register offset
   function automatic logic hits(input logic [DEC_W-1:0] a, input logic [DEC_W-1:0] off);
      return a == off;
   endfunction

   // circular enable for one space: select not parked and enable bit set
   function automatic logic spaceOn(input logic [3:0] sel, input logic en);
      return (sel != PTR_NONE) && en;
   endfunction

   // mirror of the 15-bit modifier or word index
   function automatic logic [14:0] rev15(input logic [14:0] v);
      logic [14:0] r;
      r = '0;
      for (int i = 0; i < 15; i++) begin
         r[i] = v[14 - i];
      end
      return r;
   endfunction

   // bus slave: zero wait states, frozen while the clock enable is low
   wire busTake = hsel && hready && htrans[1] && ce;
   wire wrTake = busTake && hwrite;
   wire rdTake = busTake && !hwrite;
   wire [DEC_W-1:0] busAddr = haddr[DEC_W-1:0];
   wire wrNow = wrPend_r && ce;
   // wait states come only from ce, so a stalled core stalls software too
   assign hreadyout = ce;
   assign hresp = 1'b0;
   assign hrdata = hrdata_r;

   // data-phase write lands in the selected register; 16-bit fields
   assign xStart_nxt = (wrNow && hits(wrAddr_r, OFF_X_START)) ? hwdata[15:0] : xStart_r;
   assign xEnd_nxt = (wrNow && hits(wrAddr_r, OFF_X_END)) ? hwdata[15:0] : xEnd_r;
   assign yStart_nxt = (wrNow && hits(wrAddr_r, OFF_Y_START)) ? hwdata[15:0] : yStart_r;
   assign yEnd_nxt = (wrNow && hits(wrAddr_r, OFF_Y_END)) ? hwdata[15:0] : yEnd_r;
   assign control_nxt = (wrNow && hits(wrAddr_r, OFF_CONTROL)) ? hwdata[15:0] : control_r;
   assign bitrev_nxt = (wrNow && hits(wrAddr_r, OFF_BITREV)) ? hwdata[15:0] : bitrev_r;

   // read mux looks at next values so a read right after a write sees it;
   // unmapped offsets read zero, upper half always zero
   assign rdData = hits(busAddr, OFF_X_START) ? {16'h0000, xStart_nxt} :
                   hits(busAddr, OFF_X_END) ? {16'h0000, xEnd_nxt} :
                   hits(busAddr, OFF_Y_START) ? {16'h0000, yStart_nxt} :
                   hits(busAddr, OFF_Y_END) ? {16'h0000, yEnd_nxt} :
                   hits(busAddr, OFF_CONTROL) ? {16'h0000, control_nxt} :
                   hits(busAddr, OFF_BITREV) ? {16'h0000, bitrev_nxt} : 32'h00000000;

   // bus phase tracking and read data capture
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wrPend_r <= 1'b0;
         wrAddr_r <= '0;
         hrdata_r <= 32'h00000000;
      end else if (ce) begin
         wrPend_r <= wrTake;
         wrAddr_r <= wrTake ? busAddr : wrAddr_r;
         hrdata_r <= rdTake ? rdData : hrdata_r;
      end
   end

   // register storage; software keeps control writes clear of indirect reads
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         xStart_r <= RST_START;
         xEnd_r <= RST_END;
         yStart_r <= RST_START;
         yEnd_r <= RST_END;
         control_r <= RST_CONTROL;
         bitrev_r <= RST_BITREV;
      end else if (ce) begin
         xStart_r <= xStart_nxt;
         xEnd_r <= xEnd_nxt;
         yStart_r <= yStart_nxt;
         yEnd_r <= yEnd_nxt;
         control_r <= control_nxt; // no interlock here
         bitrev_r <= bitrev_nxt;
      end
   end

   // decoded control fields; x select shared by both x generators
   wire [3:0] xSel = control_r[X_SEL_LSB +: SEL_W];
   wire [3:0] ySel = control_r[Y_SEL_LSB +: SEL_W];
   wire [3:0] brSel = control_r[BR_SEL_LSB +: SEL_W];
   wire xOn = spaceOn(xSel, control_r[X_EN_BIT]);
   wire yOn = spaceOn(ySel, control_r[Y_EN_BIT]);
   wire brOn = spaceOn(brSel, bitrev_r[BR_EN_BIT]);
   wire [14:0] brMod = bitrev_r[BR_MOD_W-1:0];

   agen_req_t reqV [NGEN];
   agen_rsp_t rspV [NGEN];
   logic [15:0] sumV [NGEN];
   logic [15:0] fixV [NGEN];
   logic upOkV [NGEN];
   logic loOkV [NGEN];
   logic modOnV [NGEN];
   logic brActV [NGEN];

   assign reqV[GEN_XR] = xrReq;
   assign reqV[GEN_XW] = xwReq;
   assign reqV[GEN_Y] = yReq;
   assign xrRsp = rspV[GEN_XR];
   assign xwRsp = rspV[GEN_XW];
   assign yRsp = rspV[GEN_Y];

   // one generator per lane; only the y lane sees the y bounds
   for (genvar g = 0; g < NGEN; g++) begin : lane
      localparam bit IS_Y = (g == GEN_Y);
      localparam bit IS_XW = (g == GEN_XW);
      agen_rsp_t rsp_r, rsp_nxt;
      logic [15:0] fixed, rawEa, rawWb, brNew;
      logic [14:0] brWord;
      wire [15:0] lo = IS_Y ? yStart_r : xStart_r;
      wire [15:0] hi = IS_Y ? yEnd_r : xEnd_r;
      wire modify = (reqV[g].mode == MODE_PRE) || (reqV[g].mode == MODE_POST);
      wire incr = !reqV[g].offset[15] && (reqV[g].offset != 16'h0000);

      assign sumV[g] = reqV[g].ptr + reqV[g].offset;

      circ_fix u_fix (
         .startAddr(lo),
         .endAddr(hi),
         .sumAddr(sumV[g]),
         .fixedAddr(fixed),
         .upperChk(upOkV[g]),
         .lowerChk(loOkV[g])
      );

      // folded sum kept per lane so that the checks below can see it
      assign fixV[g] = fixed;

      // selected pointer, any register number but 15, in this space
      assign modOnV[g] = (IS_Y ? yOn : xOn) && (reqV[g].ptrSel == (IS_Y ? ySel : xSel));

      // x write only, word-sized pre/post increment on the chosen pointer
      assign brActV[g] = IS_XW && brOn && (reqV[g].ptrSel == brSel) && modify && incr
                         && reqV[g].wordSize;

      // reverse-carry add: mirror, add modifier, mirror back
      assign brWord = rev15(rev15(reqV[g].ptr[15:1]) + rev15(brMod));
      assign brNew = {brWord, 1'b0}; // word addresses only

      // corrected or raw sum; y keeps bit zero clear when circular
      assign rawWb = modOnV[g] ? (IS_Y ? {fixV[g][15:1], 1'b0} : fixV[g]) : sumV[g];

      // address driven on the bus for the access itself
      always_comb begin
         rawEa = reqV[g].ptr;
         unique case (reqV[g].mode)
            MODE_INDIRECT: rawEa = reqV[g].ptr;
            MODE_POST: rawEa = reqV[g].ptr;
            MODE_PRE: rawEa = rawWb;
            MODE_OFFSET: rawEa = rawWb; // corrected but not stored
         endcase
      end

      // bit reversal has priority over circular on the x write lane
      always_comb begin
         rsp_nxt = '0;
         rsp_nxt.valid = reqV[g].valid;
         rsp_nxt.wbSel = reqV[g].ptrSel;
         rsp_nxt.wbEn = reqV[g].valid && modify;
         if (brActV[g]) begin
            rsp_nxt.wbData = brNew;
            rsp_nxt.ea = (reqV[g].mode == MODE_PRE) ? brNew : {reqV[g].ptr[15:1], 1'b0};
         end else begin
            rsp_nxt.wbData = rawWb;
            rsp_nxt.ea = (IS_Y && modOnV[g]) ? {rawEa[15:1], 1'b0} : rawEa;
         end
      end

      // answers are registered one cycle after the request
      always_ff @(posedge mclk or posedge rst) begin
         if (rst) begin
            rsp_r <= '0;
         end else if (ce) begin
            rsp_r <= rsp_nxt;
         end
      end

      assign rspV[g] = rsp_r;
   end

   // checks
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   chk_y_word_lsb: assert property (
      ce && yReq.valid && yOn && (yReq.ptrSel == ySel) |=> !yRsp.ea[0] && !yRsp.wbData[0])
      else $error("y circular address has bit zero set");

   chk_offset_keeps_ptr: assert property (
      ce && xrReq.valid && (xrReq.mode == MODE_OFFSET) |=> xrRsp.valid && !xrRsp.wbEn)
      else $error("register offset mode wrote the pointer back");

   chk_post_uses_ptr: assert property (
      ce && xrReq.valid && (xrReq.mode == MODE_POST) |=> xrRsp.wbEn && xrRsp.ea == $past(xrReq.ptr))
      else $error("post modify access not at old pointer");

   chk_x_parked_plain: assert property (
      ce && xrReq.valid && (xSel == PTR_NONE) && (xrReq.mode == MODE_PRE)
      |=> xrRsp.ea == $past(sumV[GEN_XR]))
      else $error("x correction active although select is parked");

   chk_upper_wrap_in: assert property (
      ce && yReq.valid && modOnV[GEN_Y] && upOkV[GEN_Y] && (yReq.mode == MODE_PRE)
      && (sumV[GEN_Y] > yEnd_r) && (sumV[GEN_Y] - yEnd_r <= yEnd_r - yStart_r + 16'h0001)
      |=> (yRsp.ea >= $past(yStart_r)) && (yRsp.ea <= $past(yEnd_r)))
      else $error("upper overshoot not folded into the buffer");

   chk_no_lower_fix: assert property (
      ce && xrReq.valid && modOnV[GEN_XR] && !loOkV[GEN_XR] && (xrReq.mode == MODE_PRE)
      && (sumV[GEN_XR] < xStart_r) |=> xrRsp.ea == $past(sumV[GEN_XR]))
      else $error("incrementing buffer corrected at its lower bound");

   chk_bitrev_word: assert property (
      ce && xwReq.valid && brActV[GEN_XW] |=> xwRsp.wbEn && !xwRsp.wbData[0] && !xwRsp.ea[0])
      else $error("bit-reversed write-back not word aligned");

   chk_read_lane_plain: assert property (
      ce && xrReq.valid && !modOnV[GEN_XR] && (xrReq.mode == MODE_PRE)
      |=> xrRsp.wbData == $past(sumV[GEN_XR]))
      else $error("x read lane altered without circular mode");

   chk_reg_readback: assert property (
      wrTake && hits(busAddr, OFF_X_END) && ce ##1 ce
      |-> ##1 xEnd_r == $past(hwdata[15:0]))
      else $error("x end register did not take the written value");

   // the x buffer folds back from above just as the y one does
   chk_x_wrap_in: assert property (
      ce && xrReq.valid && modOnV[GEN_XR] && upOkV[GEN_XR] && (xrReq.mode == MODE_PRE)
      && (sumV[GEN_XR] > xEnd_r) && (sumV[GEN_XR] - xEnd_r <= xEnd_r - xStart_r + 16'h0001)
      |=> (xrRsp.ea >= $past(xStart_r)) && (xrRsp.ea <= $past(xEnd_r)))
      else $error("x upper overshoot not folded into the buffer");

   // an undershoot of at most one length lands back inside the buffer
   chk_lower_wrap_in: assert property (
      ce && yReq.valid && modOnV[GEN_Y] && loOkV[GEN_Y] && (yReq.mode == MODE_PRE)
      && (sumV[GEN_Y] < yStart_r) && (yStart_r - sumV[GEN_Y] <= yEnd_r - yStart_r + 16'h0001)
      |=> (yRsp.ea >= $past(yStart_r)) && (yRsp.ea <= $past(yEnd_r)))
      else $error("lower undershoot not folded into the buffer");

   // a decrementing buffer leaves an upward crossing alone
   chk_no_upper_fix: assert property (
      ce && yReq.valid && modOnV[GEN_Y] && !upOkV[GEN_Y] && (yReq.mode == MODE_PRE)
      && (sumV[GEN_Y] > yEnd_r) |=> yRsp.ea[15:1] == $past(sumV[GEN_Y][15:1]))
      else $error("decrementing buffer corrected at its upper bound");

   // with y circular mode off the y lane writes back the plain sum
   chk_y_off_plain: assert property (
      ce && yReq.valid && !yOn && ((yReq.mode == MODE_PRE) || (yReq.mode == MODE_POST))
      |=> yRsp.wbData == $past(sumV[GEN_Y]))
      else $error("y lane corrected although y circular mode is off");

   // neither reversal nor circular mode: the x write lane is a plain adder
   chk_xw_plain: assert property (
      ce && xwReq.valid && !brActV[GEN_XW] && !modOnV[GEN_XW]
      |=> xwRsp.wbData == $past(sumV[GEN_XW]))
      else $error("x write lane altered without reversal or circular mode");

   // the write-back goes to the pointer that made the request
   chk_wb_sel_echo: assert property (
      ce && yReq.valid |=> yRsp.valid && (yRsp.wbSel == $past(yReq.ptrSel)))
      else $error("write-back aimed at another pointer");

   // a low clock enable must not let the x bounds, the control register or the y answer drift
   chk_ce_holds_regs: assert property (
      !ce |=> $stable(xStart_r) && $stable(xEnd_r) && $stable(control_r) && $stable(yRsp))
      else $error("state changed while the clock enable was low");

   // one cover per main scenario, to show that the bench reaches it
   cov_upper_wrap: cover property (
      ce && yReq.valid && modOnV[GEN_Y] && (sumV[GEN_Y] > yEnd_r) && upOkV[GEN_Y]);
   cov_lower_wrap: cover property (
      ce && yReq.valid && modOnV[GEN_Y] && (sumV[GEN_Y] < yStart_r) && loOkV[GEN_Y]);
   cov_bidir_wrap: cover property (
      ce && yReq.valid && modOnV[GEN_Y] && upOkV[GEN_Y] && loOkV[GEN_Y]);
   cov_bitrev: cover property (ce && xwReq.valid && brActV[GEN_XW]);
   cov_bus_rw: cover property (wrTake ##2 rdTake);

endmodule

// file: verilog/circ_addr_pkg.sv
// shared constants and carriers for the circular buffer address generator
// assumes a 16-bit data address space and an AHB-Lite register port
package circ_addr_pkg;

   // register byte offsets on the bus
   localparam logic [7:0] OFF_X_START = 8'h00;
   localparam logic [7:0] OFF_X_END = 8'h04;
   localparam logic [7:0] OFF_Y_START = 8'h08;
   localparam logic [7:0] OFF_Y_END = 8'h0c;
   localparam logic [7:0] OFF_CONTROL = 8'h10;
   localparam logic [7:0] OFF_BITREV = 8'h14;
   localparam int unsigned DEC_W = 8;

   // reset values
   localparam logic [15:0] RST_START = 16'h0000;
   localparam logic [15:0] RST_END = 16'h0000;
   localparam logic [15:0] RST_CONTROL = 16'h0000;
   localparam logic [15:0] RST_BITREV = 16'h0000;

   // control register fields
   localparam int unsigned X_SEL_LSB = 0;
   localparam int unsigned Y_SEL_LSB = 4;
   localparam int unsigned BR_SEL_LSB = 8;
   localparam int unsigned SEL_W = 4;
   localparam int unsigned Y_EN_BIT = 14;
   localparam int unsigned X_EN_BIT = 15;
   // bit-reverse register fields, then the parked select value
   localparam int unsigned BR_EN_BIT = 15;
   localparam int unsigned BR_MOD_W = 15;
   localparam logic [3:0] PTR_NONE = 4'hf;

   // AHB-Lite constants
   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
   localparam logic [2:0] HSIZE_WORD = 3'h2;

   typedef enum logic [1:0] {
      MODE_INDIRECT = 2'b00,
      MODE_POST = 2'b01,
      MODE_PRE = 2'b10,
      MODE_OFFSET = 2'b11
   } addr_mode_t;

   // one address request from the core
   typedef struct packed {
      logic valid;
      logic [3:0] ptrSel;
      logic [15:0] ptr;
      logic [15:0] offset;
      addr_mode_t mode;
      logic wordSize;
   } agen_req_t;

   // registered answer: access address and pointer write-back
   typedef struct packed {
      logic valid;
      logic [15:0] ea;
      logic wbEn;
      logic [3:0] wbSel;
      logic [15:0] wbData;
   } agen_rsp_t;

   // sets every bit below the highest set bit
   function automatic logic [15:0] fillBelow(input logic [15:0] v);
      logic [15:0] r;
      r = v;
      for (int i = 1; i < 16; i = i * 2) begin
         r = r | (r >> i);
      end
      return r;
   endfunction

endpackage

// file: verilog/circ_fix.sv
// boundary check and wrap of one effective address against one buffer
// assumes start/end hold first and last byte address; purely combinational
module circ_fix
   import circ_addr_pkg::*;
(
   input wire logic [15:0] startAddr,
   input wire logic [15:0] endAddr,
   input wire logic [15:0] sumAddr,
   output logic [15:0] fixedAddr,
   output logic upperChk,
   output logic lowerChk
);

   logic [15:0] span;
   logic [15:0] lowMask;
   logic [16:0] bufLen;
   logic overUpper;
   logic underLower;
   logic [16:0] wrapDown;
   logic [16:0] wrapUp;

   // length is implied by the two bounds, no length register
   assign span = endAddr - startAddr;
   assign bufLen = {1'b0, span} + 17'h00001;
   assign lowMask = fillBelow(span);

   // zero-aligned start marks an incrementing buffer, ones-aligned end a
   // decrementing one; both at once gives a two-way buffer
   assign upperChk = (startAddr & lowMask) == 16'h0000;
   assign lowerChk = (endAddr & lowMask) == lowMask;

   // magnitude compares so any overshoot is caught, not just equality
   assign overUpper = upperChk && (sumAddr > endAddr);
   assign underLower = lowerChk && (sumAddr < startAddr);

   // subtract or add one buffer length to fold back inside
   assign wrapDown = {1'b0, sumAddr} - bufLen;
   assign wrapUp = {1'b0, sumAddr} + bufLen;
   assign fixedAddr = overUpper ? wrapDown[15:0] :
                      (underLower ? wrapUp[15:0] : sumAddr);

endmodule

// file: bench/core_model.sv
// core-side partner: issues address requests and keeps the pointer file
// assumes the generator answers one mclk after a request is taken
module core_model
   import circ_addr_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire agen_rsp_t xrRsp,
   input wire agen_rsp_t xwRsp,
   input wire agen_rsp_t yRsp,
   output agen_req_t xrReq,
   output agen_req_t xwReq,
   output agen_req_t yReq
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] ptrFile [16];

   // idle lanes from time zero so nothing is taken during reset
   initial begin
      xrReq = '0;
      xwReq = '0;
      yReq = '0;
   end

   // pointers change only where the answer flags a write-back
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < 16; i++)
            ptrFile[i] <= 16'h0000;
      end else begin
         if (xrRsp.valid && xrRsp.wbEn)
            ptrFile[xrRsp.wbSel] <= xrRsp.wbData;
         if (xwRsp.valid && xwRsp.wbEn)
            ptrFile[xwRsp.wbSel] <= xwRsp.wbData;
         if (yRsp.valid && yRsp.wbEn)
            ptrFile[yRsp.wbSel] <= yRsp.wbData;
      end
   end

   // one request, one cycle wide; callers never pick the stack pointers
   task automatic issue(input logic [1:0] lane, input logic [3:0] sel,
      input logic [15:0] ptr, input logic [15:0] off, input addr_mode_t mode,
      input logic ws);
      agen_req_t r;
      r = '{1'b1, sel, ptr, off, mode, ws};
      @(posedge mclk);
      case (lane)
         2'd0: xrReq <= r;
         2'd1: xwReq <= r;
         default: yReq <= r;
      endcase
      @(posedge mclk);
      xrReq <= '0;
      xwReq <= '0;
      yReq <= '0;
   endtask
endmodule

// file: bench/tb.sv
// self-checking bench for the circular buffer address generator
// assumes one slave on the bus, hready looped from hreadyout
module tb
   import circ_addr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic [1:0] lane;
      logic [3:0] sel;
      logic [15:0] ptr;
      logic [15:0] off;
      addr_mode_t mode;
      logic ws;
      logic [15:0] ea;
      logic wb;
      logic [15:0] wbd;
   } row_t;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = '0;
   logic [1:0] htrans = '0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = HSIZE_WORD;
   logic [31:0] hwdata = '0;
   logic hreadyout, hresp;
   logic [31:0] hrdata, rd;
   agen_req_t xrReq, xwReq, yReq;
   agen_rsp_t xrRsp, xwRsp, yRsp;
   int miscompares = 0;
   int checked = 0;
   int cyc = 0;
   row_t rows [10];

   always #50 mclk = ~mclk;

   circ_addr_gen dut (.mclk(mclk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .xrReq(xrReq), .xwReq(xwReq), .yReq(yReq), .xrRsp(xrRsp), .xwRsp(xwRsp),
      .yRsp(yRsp));
   core_model core (.mclk(mclk), .rst(rst), .xrRsp(xrRsp), .xwRsp(xwRsp),
      .yRsp(yRsp), .xrReq(xrReq), .xwReq(xwReq), .yReq(yReq));

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // a hung handshake ends the run as a failure
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         tally_and_finish();
      end
   end

   task automatic chk(input string nm, input logic [39:0] exp, input logic [39:0] seen);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // single transfer: hold each phase until hready is seen high
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      @(posedge mclk);
      while (hreadyout !== 1'b1)
         @(posedge mclk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge mclk);
      while (hreadyout !== 1'b1)
         @(posedge mclk);
      rd = hrdata;
   endtask

   task automatic rdChk(input logic [7:0] a, input logic [15:0] exp);
      bus(1'b0, a, '0);
      chk("register", {24'h0, exp}, {8'h0, rd});
   endtask

   function automatic agen_rsp_t pick(input logic [1:0] l);
      return (l == 2'd0) ? xrRsp : (l == 2'd1) ? xwRsp : yRsp;
   endfunction

   // answer is registered, so it is looked at just after the taking edge;
   // the partner stores the write-back one edge later; ends on an edge
   task automatic runRow(input row_t r);
      agen_rsp_t s;
      core.issue(r.lane, r.sel, r.ptr, r.off, r.mode, r.ws);
      #1;
      s = pick(r.lane);
      chk("rsp", {18'h0, 1'b1, r.wb, r.sel, r.ea},
         {18'h0, s.valid, s.wbEn, s.wbSel, s.ea});
      if (r.wb)
         chk("wbData", {24'h0, r.wbd}, {24'h0, s.wbData});
      @(posedge mclk);
      #1;
      if (r.wb)
         chk("ptrFile", {24'h0, r.wbd}, {24'h0, core.ptrFile[r.sel]});
      @(posedge mclk);
   endtask

   initial begin
      // incrementing x buffer 0x2000..0x2063, decrementing y 0x201c..0x207f
      rows[0] = '{0, 3, 16'h2062, 16'h0002, MODE_PRE, 1, 16'h2000, 1, 16'h2000};
      rows[1] = '{0, 3, 16'h2060, 16'h0010, MODE_POST, 1, 16'h2060, 1, 16'h200c};
      rows[2] = '{0, 3, 16'h2002, 16'hfffc, MODE_PRE, 1, 16'h1ffe, 1, 16'h1ffe};
      rows[3] = '{0, 3, 16'h2060, 16'h0008, MODE_OFFSET, 1, 16'h2004, 0, 16'h0};
      rows[4] = '{0, 4, 16'h2062, 16'h0002, MODE_PRE, 1, 16'h2064, 1, 16'h2064};
      rows[5] = '{0, 3, 16'h2070, 16'h0002, MODE_INDIRECT, 1, 16'h2070, 0, 16'h0};
      rows[6] = '{1, 3, 16'h2062, 16'h0002, MODE_PRE, 1, 16'h2000, 1, 16'h2000};
      rows[7] = '{2, 5, 16'h201e, 16'hfffc, MODE_PRE, 1, 16'h207e, 1, 16'h207e};
      rows[8] = '{2, 5, 16'h207e, 16'h0004, MODE_PRE, 1, 16'h2082, 1, 16'h2082};
      rows[9] = '{2, 5, 16'h2031, 16'h0002, MODE_POST, 1, 16'h2030, 1, 16'h2032};
      repeat (6) @(posedge mclk);
      chk("rstRsp", '0, {2'h0, xrRsp});
      rst <= 1'b0;
      for (int a = 0; a < 6; a++)
         rdChk(8'(a * 4), 16'h0000);
      $display("test reset done");
      // start even and zero-aligned for x, end odd and ones-aligned for y
      bus(1'b1, OFF_X_START, 32'h0000_2000);
      bus(1'b1, OFF_X_END, 32'h0000_2063);
      bus(1'b1, OFF_Y_START, 32'h0000_201c);
      bus(1'b1, OFF_Y_END, 32'h0000_207f);
      bus(1'b1, OFF_CONTROL, 32'h0000_c053);
      // a spare cycle after the control write before any indirect read
      @(posedge mclk);
      for (int i = 0; i < 10; i++)
         runRow(rows[i]);
      $display("test table done");
      // only 16 bits stored; unmapped offset drops writes and reads zero
      bus(1'b1, OFF_BITREV, 32'hffff_0000);
      rdChk(OFF_BITREV, 16'h0000);
      bus(1'b1, 8'h18, 32'h0000_1234);
      rdChk(8'h18, 16'h0000);
      rdChk(OFF_X_END, 16'h2063);
      chk("hresp", '0, {39'h0, hresp});
      $display("test registers done");
      // power-of-two y buffer wraps at both ends
      bus(1'b1, OFF_Y_START, 32'h0000_3000);
      bus(1'b1, OFF_Y_END, 32'h0000_303f);
      @(posedge mclk);
      runRow('{2, 5, 16'h3000, 16'hfffe, MODE_PRE, 1, 16'h303e, 1, 16'h303e});
      runRow('{2, 5, 16'h303e, 16'h0002, MODE_PRE, 1, 16'h3000, 1, 16'h3000});
      $display("test bidirectional done");
      // x enable clear, then x select 15, then y enable clear
      bus(1'b1, OFF_CONTROL, 32'h0000_4053);
      @(posedge mclk);
      runRow('{0, 3, 16'h2062, 16'h0002, MODE_PRE, 1, 16'h2064, 1, 16'h2064});
      bus(1'b1, OFF_CONTROL, 32'h0000_c05f);
      @(posedge mclk);
      runRow('{1, 15, 16'h2062, 16'h0002, MODE_PRE, 1, 16'h2064, 1, 16'h2064});
      bus(1'b1, OFF_CONTROL, 32'h0000_8053);
      @(posedge mclk);
      runRow('{2, 5, 16'h2031, 16'h0002, MODE_POST, 1, 16'h2031, 1, 16'h2033});
      $display("test enables done");
      // 16-word reversal on pointer 2: index order 0, 8, 4
      bus(1'b1, OFF_BITREV, 32'h0000_8008);
      bus(1'b1, OFF_CONTROL, 32'h0000_82ff);
      @(posedge mclk);
      runRow('{1, 2, 16'h4000, 16'h0002, MODE_POST, 1, 16'h4000, 1, 16'h4010});
      runRow('{1, 2, 16'h4010, 16'h0002, MODE_PRE, 1, 16'h4008, 1, 16'h4008});
      runRow('{0, 2, 16'h4000, 16'h0002, MODE_POST, 1, 16'h4000, 1, 16'h4002});
      runRow('{1, 2, 16'h4000, 16'h0002, MODE_OFFSET, 1, 16'h4002, 0, 16'h0});
      runRow('{1, 2, 16'h4000, 16'h0002, MODE_POST, 0, 16'h4000, 1, 16'h4002});
      $display("test bitrev done");
      // stalled clock enable holds the bus off and freezes the answers
      ce <= 1'b0;
      @(posedge mclk);
      #1;
      chk("hreadyout", '0, {39'h0, hreadyout});
      core.issue(2'd0, 4'd3, 16'h2062, 16'h0002, MODE_PRE, 1'b1);
      #1;
      chk("ceFreeze", '0, {39'h0, xrRsp.valid});
      @(posedge mclk);
      ce <= 1'b1;
      $display("test ce done");
      // reset in mid-run clears the x end and control registers and the y answer
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      rdChk(OFF_X_END, 16'h0000);
      rdChk(OFF_CONTROL, 16'h0000);
      chk("midRstRsp", '0, {2'h0, yRsp});
      $display("test mid reset done");
      tally_and_finish();
   end
endmodule
